// [design/sse_exec.sv]
// Operation
// [RULE1] Opcode 00 0000 0110 0011 decodes as power-down; no operands, one word.
// [RULE2] Power-down sets the watchdog expiry flag to one.
// [RULE3] Power-down clears the powerdown flag to zero.
// [RULE4] Power-down loads watchdog counter with 00h and clears its prescaler.
// [RULE5] After power-down the core sleeps with its oscillator halted.
// [RULE6] Encoding 11 110x kkkk kkkk computes literal minus accumulator.
// [RULE7] Literal subtract writes its difference into the accumulator.
// [RULE8] Encoding 00 0010 dfff ffff computes file register minus accumulator.
// [RULE9] Destination bit 0 writes accumulator, 1 writes back the file register.
// [RULE10] Carry set to one when the difference is zero or positive.
// [RULE11] Carry cleared on borrow; the result wraps modulo 256.
// [RULE12] Zero and nibble borrow flags updated; each subtract takes one instruction cycle.
`timescale 1ns/1ps
module sse_exec #(
  parameter int WDOG_TICK_CYC = sse_pkg::WDOG_TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [13:0] instr,
  input  wire logic        instr_valid,
  output logic             instr_ready_q,
  input  wire logic        wake_pin,
  input  wire logic [3:0]  bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata_q,
  output logic             irq_q,
  output logic             osc_run_q,
  output logic             watchdog_expiry_flag_q,
  output logic             powerdown_flag_q
);

  logic             rst_sync1_q;
  logic             rst_n_q;
  logic             wake_meta_q;
  logic             wake_sync_q;
  sse_pkg::sse_state_t state_q;
  sse_pkg::sse_state_t state_d;
  sse_pkg::sse_op_t    op;
  sse_pkg::sse_op_t    op_q;
  logic             take;
  logic [7:0]       acc_q;
  logic [7:0]       literal_q;
  logic [6:0]       faddr_q;
  logic             dest_q;
  logic             carry_q;
  logic             nibble_q;
  logic             zero_q;
  logic [7:0]       wdog_count_q;
  logic [7:0]       prescale_q;
  logic [15:0]      tick_cnt_q;
  logic             tick;
  logic             wdog_overflow;
  logic [7:0]       ctrl_q;
  logic [6:0]       file_addr_q;
  logic [4:0]       int_status_q;
  logic [4:0]       int_enable_q;
  logic [4:0]       events;
  logic             wake_req;
  logic [7:0]       sub_a;
  logic [7:0]       sub_diff;
  logic             sub_carry;
  logic             sub_nibble;
  logic             sub_zero;
  logic             exec_now;
  logic             exec_file_wr;
  logic             bus_file_wr;
  logic             pend_q;
  logic [7:0]       pend_data_q;
  logic [6:0]       pend_addr_q;
  logic             mem_wr_en;
  logic [6:0]       mem_wr_addr;
  logic [7:0]       mem_wr_data;
  logic [6:0]       mem_rd_addr;
  logic [7:0]       mem_rd_data;
  logic             wr_sleep;

  // Reset release through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync1_q <= 1'b0;
      rst_n_q     <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_n_q     <= rst_sync1_q;
    end
  end

  // Wake pin comes from outside the clock domain
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
    end else begin
      wake_meta_q <= wake_pin;
      wake_sync_q <= wake_meta_q;
    end
  end

  assign op       = sse_pkg::sse_decode(instr); // [RULE1]
  assign take     = instr_valid && instr_ready_q;
  assign exec_now = (state_q == sse_pkg::SSE_EXEC);
  assign wr_sleep = take && (op == sse_pkg::SSE_OP_SLEEP);
  assign wake_req = wake_sync_q || wdog_overflow ||
                    (bus_wr && bus_addr == sse_pkg::REG_CTRL && bus_wdata[sse_pkg::CTRL_WAKE]);

  // Sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      sse_pkg::SSE_IDLE: begin
        if (take && op == sse_pkg::SSE_OP_SLEEP) begin
          state_d = sse_pkg::SSE_ASLEEP; // [RULE5]
        end else if (take && op != sse_pkg::SSE_OP_NONE) begin
          state_d = sse_pkg::SSE_EXEC;
        end
      end
      sse_pkg::SSE_EXEC: begin
        state_d = sse_pkg::SSE_IDLE; // [RULE12]
      end
      sse_pkg::SSE_ASLEEP: begin
        if (wake_req) begin
          state_d = sse_pkg::SSE_IDLE;
        end
      end
      default: begin
        state_d = sse_pkg::SSE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q       <= sse_pkg::SSE_IDLE;
      instr_ready_q <= 1'b0;
      osc_run_q     <= 1'b1;
    end else begin
      state_q       <= state_d;
      instr_ready_q <= (state_d == sse_pkg::SSE_IDLE);
      osc_run_q     <= (state_d != sse_pkg::SSE_ASLEEP); // [RULE5]
    end
  end

  // Operand capture on acceptance
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      op_q      <= sse_pkg::SSE_OP_NONE;
      literal_q <= 8'h00;
      faddr_q   <= 7'h00;
      dest_q    <= 1'b0;
    end else if (take) begin
      op_q      <= op;
      literal_q <= instr[7:0];
      faddr_q   <= instr[6:0];
      dest_q    <= instr[sse_pkg::DEST_BIT];
    end
  end

  // Minuend is the literal or the file register read one cycle earlier
  assign sub_a = (op_q == sse_pkg::SSE_OP_FSUB) ? mem_rd_data : literal_q; // [RULE6] [RULE8]

  sse_sub_alu u_alu (
    .minuend    (sub_a),
    .subtrahend (acc_q),
    .diff       (sub_diff),
    .carry      (sub_carry),
    .nibble     (sub_nibble),
    .zero       (sub_zero)
  );

  assign exec_file_wr = exec_now && (op_q == sse_pkg::SSE_OP_FSUB) && dest_q; // [RULE9]

  // Accumulator
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      acc_q <= sse_pkg::ACC_RST;
    end else if (exec_now && (op_q == sse_pkg::SSE_OP_LSUB)) begin
      acc_q <= sub_diff; // [RULE7]
    end else if (exec_now && (op_q == sse_pkg::SSE_OP_FSUB) && !dest_q) begin
      acc_q <= sub_diff; // [RULE9]
    end else if (bus_wr && bus_addr == sse_pkg::REG_ACC) begin
      acc_q <= bus_wdata;
    end
  end

  // Arithmetic flags
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      carry_q  <= 1'b0;
      nibble_q <= 1'b0;
      zero_q   <= 1'b0;
    end else if (exec_now) begin
      carry_q  <= sub_carry; // [RULE10] [RULE11]
      nibble_q <= sub_nibble; // [RULE12]
      zero_q   <= sub_zero; // [RULE12]
    end
  end

  // Power-down status flags
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      watchdog_expiry_flag_q <= sse_pkg::EXPIRY_RST;
      powerdown_flag_q       <= sse_pkg::PWRDN_RST;
    end else if (wr_sleep) begin
      watchdog_expiry_flag_q <= 1'b1; // [RULE2]
      powerdown_flag_q       <= 1'b0; // [RULE3]
    end else if (wdog_overflow) begin
      watchdog_expiry_flag_q <= 1'b0;
    end
  end

  // Watchdog time base keeps running in sleep, like its own oscillator
  assign tick = ctrl_q[sse_pkg::CTRL_WDOG_RUN] && (tick_cnt_q == 16'(WDOG_TICK_CYC - 1));
  assign wdog_overflow = tick && (prescale_q == 8'hff) && (wdog_count_q == 8'hff);

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tick_cnt_q <= 16'h0000;
    end else if (wr_sleep || tick || !ctrl_q[sse_pkg::CTRL_WDOG_RUN]) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prescale_q <= sse_pkg::PRESCALE_CLR;
    end else if (wr_sleep) begin
      prescale_q <= sse_pkg::PRESCALE_CLR; // [RULE4]
    end else if (tick) begin
      prescale_q <= prescale_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wdog_count_q <= sse_pkg::WDOG_LOAD;
    end else if (wr_sleep) begin
      wdog_count_q <= sse_pkg::WDOG_LOAD; // [RULE4]
    end else if (tick && prescale_q == 8'hff) begin
      wdog_count_q <= wdog_count_q + 8'h01;
    end
  end

  // A bus write to the file is held one cycle if an instruction writes back then
  assign bus_file_wr = bus_wr && (bus_addr == sse_pkg::REG_FILE_DATA);

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_q      <= 1'b0;
      pend_data_q <= 8'h00;
      pend_addr_q <= 7'h00;
    end else if (bus_file_wr && (exec_file_wr || pend_q)) begin
      pend_q      <= 1'b1;
      pend_data_q <= bus_wdata;
      pend_addr_q <= file_addr_q;
    end else if (!exec_file_wr) begin
      pend_q      <= 1'b0;
    end
  end

  always_comb begin
    mem_wr_en   = 1'b0;
    mem_wr_addr = file_addr_q;
    mem_wr_data = bus_wdata;
    if (exec_file_wr) begin
      mem_wr_en   = 1'b1;
      mem_wr_addr = faddr_q;
      mem_wr_data = sub_diff; // [RULE9]
    end else if (pend_q) begin
      mem_wr_en   = 1'b1;
      mem_wr_addr = pend_addr_q;
      mem_wr_data = pend_data_q;
    end else if (bus_file_wr) begin
      mem_wr_en   = 1'b1;
    end
  end

  assign mem_rd_addr = take ? instr[6:0] : file_addr_q; // [RULE8]

  sse_file_mem #(
    .ADDR_W (sse_pkg::FADDR_W),
    .DATA_W (sse_pkg::DATA_W)
  ) u_file (
    .clk       (clk),
    .wr_en     (mem_wr_en),
    .wr_addr   (mem_wr_addr),
    .wr_data   (mem_wr_data),
    .rd_addr   (mem_rd_addr),
    .rd_data_q (mem_rd_data)
  );

  // Control and file address registers
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q      <= sse_pkg::CTRL_RST;
      file_addr_q <= 7'h00;
    end else if (bus_wr && bus_addr == sse_pkg::REG_CTRL) begin
      ctrl_q      <= {6'h00, 1'b0, bus_wdata[sse_pkg::CTRL_WDOG_RUN]};
    end else if (bus_wr && bus_addr == sse_pkg::REG_FILE_ADDR) begin
      file_addr_q <= bus_wdata[6:0];
    end
  end

  // Interrupt events; a set in the clearing cycle wins
  always_comb begin
    events = 5'h00;
    events[sse_pkg::EV_SLEEP]   = wr_sleep;
    events[sse_pkg::EV_SUB]     = exec_now;
    events[sse_pkg::EV_WAKE]    = (state_q == sse_pkg::SSE_ASLEEP) && wake_req;
    events[sse_pkg::EV_WDOG]    = wdog_overflow;
    events[sse_pkg::EV_UNKNOWN] = take && (op == sse_pkg::SSE_OP_NONE);
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      int_status_q <= 5'h00;
    end else if (bus_wr && bus_addr == sse_pkg::REG_INT_CLEAR) begin
      int_status_q <= (int_status_q & ~bus_wdata[4:0]) | events;
    end else begin
      int_status_q <= int_status_q | events;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      int_enable_q <= 5'h00;
    end else if (bus_wr && bus_addr == sse_pkg::REG_INT_ENABLE) begin
      int_enable_q <= bus_wdata[4:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((int_status_q & ~(bus_wr && bus_addr == sse_pkg::REG_INT_CLEAR ?
                                    bus_wdata[4:0] : 5'h00)) | events) & int_enable_q);
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bus_rdata_q <= 8'h00;
    end else if (bus_rd) begin
      case (bus_addr)
        sse_pkg::REG_ACC:        bus_rdata_q <= acc_q;
        sse_pkg::REG_STATUS:     bus_rdata_q <= {2'b00,
                                                 (state_q == sse_pkg::SSE_ASLEEP),
                                                 watchdog_expiry_flag_q,
                                                 powerdown_flag_q,
                                                 zero_q, nibble_q, carry_q};
        sse_pkg::REG_WDOG_COUNT: bus_rdata_q <= wdog_count_q;
        sse_pkg::REG_PRESCALE:   bus_rdata_q <= prescale_q;
        sse_pkg::REG_CTRL:       bus_rdata_q <= ctrl_q;
        sse_pkg::REG_FILE_ADDR:  bus_rdata_q <= {1'b0, file_addr_q};
        sse_pkg::REG_FILE_DATA:  bus_rdata_q <= mem_rd_data;
        sse_pkg::REG_INT_STATUS: bus_rdata_q <= {3'b000, int_status_q};
        sse_pkg::REG_INT_ENABLE: bus_rdata_q <= {3'b000, int_enable_q};
        default:                 bus_rdata_q <= 8'h00;
      endcase
    end else begin
      bus_rdata_q <= 8'h00;
    end
  end

endmodule

// [design/sse_file_mem.sv]
`timescale 1ns/1ps
module sse_file_mem #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  input  wire logic              clk,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data_q
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read before write: a same-cycle write shows on the next read
  always_ff @(posedge clk) begin
    rd_data_q <= mem[rd_addr];
  end
endmodule

// [design/sse_pkg.sv]
package sse_pkg;

  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 7;
  localparam int BADDR_W = 4;
  localparam int EV_W    = 5;

  // Instruction encodings
  localparam logic [13:0] SLEEP_OPCODE    = 14'h0063;
  localparam logic [4:0]  LIT_SUB_PREFIX  = 5'h1e;
  localparam logic [5:0]  FILE_SUB_PREFIX = 6'h02;
  localparam int          DEST_BIT        = 7;

  // Register word indices
  localparam logic [3:0] REG_ACC        = 4'h0;
  localparam logic [3:0] REG_STATUS     = 4'h1;
  localparam logic [3:0] REG_WDOG_COUNT = 4'h2;
  localparam logic [3:0] REG_PRESCALE   = 4'h3;
  localparam logic [3:0] REG_CTRL       = 4'h4;
  localparam logic [3:0] REG_FILE_ADDR  = 4'h5;
  localparam logic [3:0] REG_FILE_DATA  = 4'h6;
  localparam logic [3:0] REG_INT_STATUS = 4'h7;
  localparam logic [3:0] REG_INT_CLEAR  = 4'h8;
  localparam logic [3:0] REG_INT_ENABLE = 4'h9;

  // Status register fields
  localparam int STAT_CARRY  = 0;
  localparam int STAT_NIBBLE = 1;
  localparam int STAT_ZERO   = 2;
  localparam int STAT_PWRDN  = 3;
  localparam int STAT_EXPIRY = 4;
  localparam int STAT_ASLEEP = 5;

  // Control register fields
  localparam int CTRL_WDOG_RUN = 0;
  localparam int CTRL_WAKE     = 1;

  // Event bits
  localparam int EV_SLEEP   = 0;
  localparam int EV_SUB     = 1;
  localparam int EV_WAKE    = 2;
  localparam int EV_WDOG    = 3;
  localparam int EV_UNKNOWN = 4;

  // Reset values and loads
  localparam logic [7:0] ACC_RST      = 8'h00;
  localparam logic [7:0] WDOG_LOAD    = 8'h00;
  localparam logic [7:0] PRESCALE_CLR = 8'h00;
  localparam logic [7:0] CTRL_RST     = 8'h01;
  localparam logic       PWRDN_RST    = 1'b1;
  localparam logic       EXPIRY_RST   = 1'b1;

  // Watchdog tick: 1 us at 250 MHz
  localparam int CLK_MHZ        = 250;
  localparam int WDOG_TICK_US   = 1;
  localparam int WDOG_TICK_CYC  = WDOG_TICK_US * CLK_MHZ;

  typedef enum logic [1:0] {
    SSE_IDLE,
    SSE_EXEC,
    SSE_ASLEEP
  } sse_state_t;

  typedef enum logic [1:0] {
    SSE_OP_NONE,
    SSE_OP_SLEEP,
    SSE_OP_LSUB,
    SSE_OP_FSUB
  } sse_op_t;

  function automatic sse_op_t sse_decode(input logic [13:0] w);
    sse_op_t op;
    op = SSE_OP_NONE;
    if (w == SLEEP_OPCODE) begin
      op = SSE_OP_SLEEP;
    end else if (w[13:9] == LIT_SUB_PREFIX) begin
      op = SSE_OP_LSUB;
    end else if (w[13:8] == FILE_SUB_PREFIX) begin
      op = SSE_OP_FSUB;
    end
    return op;
  endfunction

endpackage

// [design/sse_sub_alu.sv]
`timescale 1ns/1ps
module sse_sub_alu (
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  output logic      [7:0] diff,
  output logic            carry,
  output logic            nibble,
  output logic            zero
);
  logic [8:0] full;
  logic [4:0] low;

  // Two's complement: add the inverted subtrahend plus one
  assign full   = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
  assign low    = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
  assign diff   = full[7:0];
  assign carry  = full[8];
  assign nibble = low[4];
  assign zero   = (full[7:0] == 8'h00);
endmodule

// [sim/sse_exec_asserts.sv]
`timescale 1ns/1ps
module sse_exec_asserts #(
  parameter int WDOG_TICK_CYC = sse_pkg::WDOG_TICK_CYC
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [13:0] instr,
  input wire logic        instr_valid,
  input wire logic        instr_ready_q,
  input wire logic        wake_pin,
  input wire logic [3:0]  bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_rdata_q,
  input wire logic        irq_q,
  input wire logic        osc_run_q,
  input wire logic        watchdog_expiry_flag_q,
  input wire logic        powerdown_flag_q
);
  logic take;
  logic sleep_go;
  logic sub_go;

  assign take     = instr_valid && instr_ready_q;
  assign sleep_go = take && (instr == sse_pkg::SLEEP_OPCODE);
  assign sub_go   = take && ((instr[13:9] == sse_pkg::LIT_SUB_PREFIX) ||
                             (instr[13:8] == sse_pkg::FILE_SUB_PREFIX));

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_sleep_osc;
    sleep_go |=> !osc_run_q;
  endproperty
  a_sleep_osc: assert property (p_sleep_osc) else $error("oscillator still running");

  property p_osc_cause;
    $fell(osc_run_q) |-> $past(sleep_go);
  endproperty
  a_osc_cause: assert property (p_osc_cause) else $error("oscillator stopped without cause");

  property p_sleep_to;
    sleep_go |=> watchdog_expiry_flag_q [*2];
  endproperty
  a_sleep_to: assert property (p_sleep_to) else $error("expiry flag not set");

  property p_sleep_pd;
    sleep_go |=> !powerdown_flag_q;
  endproperty
  a_sleep_pd: assert property (p_sleep_pd) else $error("powerdown flag not cleared");

  property p_pd_cause;
    $fell(powerdown_flag_q) |-> $past(sleep_go);
  endproperty
  a_pd_cause: assert property (p_pd_cause) else $error("powerdown flag cleared without cause");

  property p_sleep_hold;
    sleep_go |=> !instr_ready_q;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("ready while asleep");

  property p_sub_cycle;
    sub_go |=> !instr_ready_q ##1 instr_ready_q;
  endproperty
  a_sub_cycle: assert property (p_sub_cycle) else $error("subtract cycle length wrong");

  property p_other_awake;
    take && !sleep_go |=> osc_run_q;
  endproperty
  a_other_awake: assert property (p_other_awake) else $error("non sleep word stopped clock");

  c_sleep: cover property (sleep_go);
  c_sub: cover property (sub_go);
endmodule

bind sse_exec sse_exec_asserts #(.WDOG_TICK_CYC(WDOG_TICK_CYC)) u_chk (
  .clk(clk), .resetn(resetn), .instr(instr), .instr_valid(instr_valid),
  .instr_ready_q(instr_ready_q), .wake_pin(wake_pin), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q),
  .irq_q(irq_q), .osc_run_q(osc_run_q), .watchdog_expiry_flag_q(watchdog_expiry_flag_q),
  .powerdown_flag_q(powerdown_flag_q));

// [sim/test_sleep_and_subtract_exec.sv]
`timescale 1ns/1ps
module test_sleep_and_subtract_exec;
  localparam int TICK = 4;
  typedef struct packed {
    logic [1:0] kind;
    logic [6:0] f;
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] res;
  } sse_row_t;

  logic        clk;
  logic        resetn;
  logic [13:0] instr;
  logic        instr_valid;
  logic        instr_ready_q;
  logic        wake_pin;
  logic [3:0]  bus_addr;
  logic [7:0]  bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  bus_rdata_q;
  logic        irq_q;
  logic        osc_run_q;
  logic        wd_flag;
  logic        pwrdn_flag;
  int          n_fail;
  int          tests_run;
  logic [7:0]  rd;
  sse_row_t    rows [8];

  sse_exec #(.WDOG_TICK_CYC(TICK)) dut_u (
    .clk(clk), .resetn(resetn), .instr(instr), .instr_valid(instr_valid),
    .instr_ready_q(instr_ready_q), .wake_pin(wake_pin), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q),
    .irq_q(irq_q), .osc_run_q(osc_run_q), .watchdog_expiry_flag_q(wd_flag),
    .powerdown_flag_q(pwrdn_flag));

  always #2 clk = ~clk;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  task automatic bus_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata_q;
  endtask

  task automatic wait_ready();
    int i;
    i = 0;
    @(negedge clk);
    while (instr_ready_q !== 1'b1 && i < 300) begin
      @(negedge clk);
      i++;
    end
    // A core that never comes back counts as a failure
    if (instr_ready_q !== 1'b1) begin
      n_fail++;
    end
  endtask

  // Offers one word; the take happens at the second edge
  task automatic exec(input logic [13:0] w);
    wait_ready();
    @(posedge clk);
    instr <= w;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic final_report();
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    final_report();
  end

  initial begin
    clk = 1'b0; resetn = 1'b0; instr = 14'h0000; instr_valid = 1'b0; wake_pin = 1'b0;
    bus_addr = 4'h0; bus_wdata = 8'h00; bus_wr = 1'b0; bus_rd = 1'b0;
    n_fail = 0; tests_run = 0;
    // Kind: 0/1 literal form with bit 8 low/high, 2 file to acc, 3 file write-back
    rows = '{'{2'd0, 7'h00, 8'h02, 8'h01, 8'h01}, '{2'd1, 7'h00, 8'h02, 8'h02, 8'h00},
             '{2'd0, 7'h00, 8'h02, 8'h03, 8'hff}, '{2'd3, 7'h05, 8'h03, 8'h02, 8'h01},
             '{2'd3, 7'h7f, 8'h02, 8'h02, 8'h00}, '{2'd2, 7'h00, 8'h01, 8'h02, 8'hff},
             '{2'd1, 7'h00, 8'h10, 8'h01, 8'h0f}, '{2'd2, 7'h40, 8'h80, 8'h7f, 8'h01}};
    repeat (20) @(posedge clk);
    check({4'h0, osc_run_q, wd_flag, pwrdn_flag, instr_ready_q}, 8'h0e);
    resetn <= 1'b1;
    // The internal reset copy lags two edges; a bus write before then is lost
    wait_ready();
    bus_write(sse_pkg::REG_INT_ENABLE, 8'h02);
    foreach (rows[i]) begin
      bus_write(sse_pkg::REG_ACC, rows[i].w);
      if (rows[i].kind[1]) begin
        bus_write(sse_pkg::REG_FILE_ADDR, {1'b0, rows[i].f});
        bus_write(sse_pkg::REG_FILE_DATA, rows[i].a);
        exec({sse_pkg::FILE_SUB_PREFIX, rows[i].kind[0], rows[i].f});
      end else begin
        exec({sse_pkg::LIT_SUB_PREFIX, rows[i].kind[0], rows[i].a});
      end
      bus_read(sse_pkg::REG_ACC, rd);
      check(rd, (rows[i].kind == 2'd3) ? rows[i].w : rows[i].res);
      bus_read(sse_pkg::REG_STATUS, rd);
      check({5'h00, rd[2:0]}, {5'h00, rows[i].res == 8'h00, rows[i].a[3:0] >= rows[i].w[3:0],
            rows[i].a >= rows[i].w});
      if (rows[i].kind[1]) begin
        bus_read(sse_pkg::REG_FILE_DATA, rd);
        check(rd, rows[i].kind[0] ? rows[i].res : rows[i].a);
      end
    end
    settle();
    check({7'h00, irq_q}, 8'h01);
    bus_write(sse_pkg::REG_INT_CLEAR, 8'h1f);
    bus_write(sse_pkg::REG_INT_ENABLE, 8'h00);
    exec(14'h0062);
    settle();
    check({6'h00, osc_run_q, irq_q}, 8'h02);
    bus_read(sse_pkg::REG_INT_STATUS, rd);
    check(rd, 8'h10);
    bus_write(sse_pkg::REG_INT_ENABLE, 8'h10);
    settle();
    check({7'h00, irq_q}, 8'h01);
    bus_write(sse_pkg::REG_INT_CLEAR, 8'h10);
    settle();
    check({7'h00, irq_q}, 8'h00);
    check({5'h00, osc_run_q, wd_flag, pwrdn_flag}, 8'h07);
    bus_read(sse_pkg::REG_ACC, rd);
    check(rd, 8'h01);
    bus_write(sse_pkg::REG_ACC, 8'h11);
    // Let the watchdog count away from zero before the power-down
    repeat (1100) @(posedge clk);
    wait_ready();
    @(posedge clk);
    instr <= sse_pkg::SLEEP_OPCODE;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    bus_rd <= 1'b1;
    bus_addr <= sse_pkg::REG_PRESCALE;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 check(bus_rdata_q, 8'h00);
    bus_read(sse_pkg::REG_WDOG_COUNT, rd);
    check(rd, 8'h00);
    check({5'h00, osc_run_q, wd_flag, pwrdn_flag}, 8'h02);
    @(posedge clk);
    instr <= 14'h3c55;
    instr_valid <= 1'b1;
    repeat (4) @(posedge clk);
    instr_valid <= 1'b0;
    bus_read(sse_pkg::REG_ACC, rd);
    check(rd, 8'h11);
    @(posedge clk);
    wake_pin <= 1'b1;
    repeat (8) @(posedge clk);
    wake_pin <= 1'b0;
    settle();
    check({4'h0, osc_run_q, wd_flag, pwrdn_flag, instr_ready_q}, 8'h0d);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    check({4'h0, osc_run_q, wd_flag, pwrdn_flag, instr_ready_q}, 8'h0e);
    resetn <= 1'b1;
    wait_ready();
    bus_read(sse_pkg::REG_ACC, rd);
    check(rd, sse_pkg::ACC_RST);
    final_report();
  end
endmodule
